// ===== hdl/wakeup_timer.sv
// Wake-up timer with APB register access, interrupt and conversion trigger.
`timescale 1ns/1ns
`default_nettype none
module wakeup_timer
	import wakeup_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	input  wire logic        xtal_tick,
	input  wire logic        osc_tick,
	input  wire logic        core_clk_stop,
	output var  logic        irq,
	output var  logic        adc_trigger
);

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [31:0]       load_r;
	logic [31:0]       count_r;
	logic [CTRL_W-1:0] ctrl_r;
	logic [IRQ_W-1:0]  stat_r;
	logic [IRQ_W-1:0]  stat_nxt;
	logic [IRQ_W-1:0]  irq_en_r;
	logic              load_wr_r;
	logic [32:0]       step;
	logic              expire;
	logic              wr_en;
	logic              rd_en;
	logic              acc;

	tick_if tk ();

	wakeup_prescaler #(
		.DIV_W (15)
	) u_pre (
		.pclk    (pclk),
		.presetn (presetn),
		.tk      (tk)
	);

	// ------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------
	function automatic logic mapped(input logic [31:0] a);
		if (a == ADDR_LOAD) begin
			mapped = 1'b1;
		end else if (a == ADDR_COUNT) begin
			mapped = 1'b1;
		end else if (a == ADDR_CTRL) begin
			mapped = 1'b1;
		end else if (a == ADDR_IRQCLR) begin
			mapped = 1'b1;
		end else if (a == ADDR_STATUS) begin
			mapped = 1'b1;
		end else if (a == ADDR_ENABLE) begin
			mapped = 1'b1;
		end else if (a == ADDR_STATCLR) begin
			mapped = 1'b1;
		end else begin
			mapped = 1'b0;
		end
	endfunction : mapped

	// Advances the count one step; bit 32 flags an expiry (wrap past the end).
	function automatic logic [32:0] count_step(input logic [31:0] cur, input logic up,
			input logic [1:0] fmt);
		logic [7:0] hu;
		logic [7:0] se;
		logic [7:0] mi;
		logic [7:0] hr;
		logic [7:0] hmax;
		logic       ex;
		hu   = cur[7:0];
		se   = cur[15:8];
		mi   = cur[23:16];
		hr   = cur[31:24];
		hmax = (fmt == FMT_HMS23) ? HR23_MAX : HR255_MAX;
		ex   = 1'b0;
		if (fmt == FMT_HMS23 || fmt == FMT_HMS255) begin
			if (up) begin
				if (hu < HUND_MAX) begin
					hu = hu + 8'h01;
				end else begin
					hu = 8'h00;
					if (se < SEC_MAX) begin
						se = se + 8'h01;
					end else begin
						se = 8'h00;
						if (mi < SEC_MAX) begin
							mi = mi + 8'h01;
						end else begin
							mi = 8'h00;
							if (hr < hmax) begin
								hr = hr + 8'h01;
							end else begin
								hr = 8'h00;
								ex = 1'b1;
							end
						end
					end
				end
			end else begin
				if (hu != 8'h00) begin
					hu = hu - 8'h01;
				end else begin
					hu = HUND_MAX;
					if (se != 8'h00) begin
						se = se - 8'h01;
					end else begin
						se = SEC_MAX;
						if (mi != 8'h00) begin
							mi = mi - 8'h01;
						end else begin
							mi = SEC_MAX;
							if (hr != 8'h00) begin
								hr = hr - 8'h01;
							end else begin
								hr = hmax;
								ex = 1'b1;
							end
						end
					end
				end
			end
			count_step = {ex, hr, mi, se, hu};
		end else if (up) begin
			count_step = {cur == 32'hFFFFFFFF, cur + 32'h00000001};
		end else begin
			count_step = {cur == 32'h00000000, cur - 32'h00000001};
		end
	endfunction : count_step

	// ------------------------------------------------------------------
	// APB slave: one wait state, then the answer
	// ------------------------------------------------------------------
	assign acc   = psel && penable && pready;
	assign wr_en = acc && pwrite;
	assign rd_en = psel && penable && !pready && !pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !mapped(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			if (paddr == ADDR_LOAD) begin
				prdata <= load_r;
			end else if (paddr == ADDR_COUNT) begin
				prdata <= count_r;
			end else if (paddr == ADDR_CTRL) begin
				prdata <= {{(32-CTRL_W){1'b0}}, ctrl_r};
			end else if (paddr == ADDR_STATUS) begin
				prdata <= {{(32-IRQ_W){1'b0}}, stat_r};
			end else if (paddr == ADDR_ENABLE) begin
				prdata <= {{(32-IRQ_W){1'b0}}, irq_en_r};
			end else begin
				prdata <= 32'h00000000;
			end
		end else begin
			prdata <= 32'h00000000;
		end
	end

	// ------------------------------------------------------------------
	// Software-written registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= RST_CTRL;
		end else if (wr_en && paddr == ADDR_CTRL) begin
			ctrl_r <= pwdata[CTRL_W-1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_r    <= RST_LOAD;
			load_wr_r <= 1'b0;
		end else begin
			load_wr_r <= wr_en && paddr == ADDR_LOAD;
			if (wr_en && paddr == ADDR_LOAD) begin
				load_r <= pwdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_r <= '0;
		end else if (wr_en && paddr == ADDR_ENABLE) begin
			irq_en_r <= pwdata[IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------------
	// Tick source selection
	// ------------------------------------------------------------------
	// The crystal and oscillator ticks come from always-on logic, so the
	// count keeps moving while the core clock is stopped.
	always_comb begin
		case (ctrl_r[CTRL_SRC_HI:CTRL_SRC_LO])
			SRC_OSC:  tk.src_tick = osc_tick;
			SRC_CORE: tk.src_tick = !core_clk_stop;
			default:  tk.src_tick = xtal_tick;
		endcase
	end

	assign tk.presc   = ctrl_r[CTRL_PRE_HI:CTRL_PRE_LO];
	assign tk.restart = !ctrl_r[CTRL_EN];

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	assign step   = count_step(count_r, ctrl_r[CTRL_UP], ctrl_r[CTRL_FMT_HI:CTRL_FMT_LO]);
	assign expire = ctrl_r[CTRL_EN] && tk.tick && step[32];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_r <= RST_COUNT;
		end else if (load_wr_r) begin
			count_r <= load_r;
		end else if (ctrl_r[CTRL_EN] && tk.tick) begin
			if (expire && ctrl_r[CTRL_PERIOD]) begin
				count_r <= load_r;
			end else begin
				count_r <= step[31:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_trigger <= 1'b0;
		end else begin
			adc_trigger <= expire;
		end
	end

	// ------------------------------------------------------------------
	// Interrupt: a new expiry wins over a clear in the same cycle
	// ------------------------------------------------------------------
	always_comb begin
		stat_nxt = stat_r;
		if (wr_en && paddr == ADDR_IRQCLR) begin
			stat_nxt = '0;
		end else if (wr_en && paddr == ADDR_STATCLR) begin
			stat_nxt = stat_r & ~pwdata[IRQ_W-1:0];
		end
		if (expire) begin
			stat_nxt[IRQ_EXPIRE] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= '0;
			irq    <= 1'b0;
		end else begin
			stat_r <= stat_nxt;
			irq    <= |(stat_nxt & irq_en_r);
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_ready_wait: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("access phase did not answer after one wait state");

	chk_count_ro: assert property (
		wr_en && paddr == ADDR_COUNT && !(ctrl_r[CTRL_EN] && tk.tick) && !load_wr_r
			|=> $stable(count_r))
		else $error("write to the count register changed the count");

	chk_disabled_hold: assert property (
		!ctrl_r[CTRL_EN] && !load_wr_r |=> $stable(count_r))
		else $error("count moved while the timer was disabled");

	chk_down_step: assert property (
		ctrl_r[CTRL_EN] && tk.tick && !ctrl_r[CTRL_UP] && ctrl_r[5:4] == 2'h0
			&& count_r != 32'h00000000 && !load_wr_r
			|=> count_r == $past(count_r) - 32'h00000001)
		else $error("binary down count did not decrement by one");

	chk_up_step: assert property (
		ctrl_r[CTRL_EN] && tk.tick && ctrl_r[CTRL_UP] && ctrl_r[5:4] == 2'h0
			&& count_r != 32'hFFFFFFFF && !load_wr_r
			|=> count_r == $past(count_r) + 32'h00000001)
		else $error("binary up count did not increment by one");

	chk_period_reload: assert property (
		expire && ctrl_r[CTRL_PERIOD] && !load_wr_r |=> count_r == $past(load_r))
		else $error("periodic expiry did not reload from the load register");

	chk_free_wrap: assert property (
		expire && !ctrl_r[CTRL_PERIOD] && !ctrl_r[CTRL_UP] && ctrl_r[5:4] == 2'h0
			&& !load_wr_r |=> count_r == 32'hFFFFFFFF)
		else $error("free-running down count did not wrap to all ones");

	chk_irq_clear: assert property (
		wr_en && paddr == ADDR_IRQCLR && !expire |=> !stat_r[IRQ_EXPIRE] && !irq)
		else $error("clear register write did not clear the interrupt");

	chk_expire_evt: assert property (
		expire |=> adc_trigger && stat_r[IRQ_EXPIRE] && (irq == $past(irq_en_r[IRQ_EXPIRE])))
		else $error("expiry did not raise trigger and status together");

	chk_hms_range: assert property (
		ctrl_r[CTRL_EN] && tk.tick && ctrl_r[5:4] == FMT_HMS23 && !load_wr_r
			&& count_r[7:0] <= HUND_MAX |=> count_r[7:0] <= HUND_MAX)
		else $error("hundredths field left its range");

	chk_load_copy: assert property (
		wr_en && paddr == ADDR_LOAD |=> ##1 count_r == $past(pwdata, 2))
		else $error("load write was not copied into the count");

	chk_core_stopped: assert property (
		$past(core_clk_stop) && $past(ctrl_r[CTRL_SRC_HI:CTRL_SRC_LO]) == SRC_CORE && !load_wr_r
			|=> $stable(count_r))
		else $error("count moved on the core source while the core clock was stopped");

	chk_err_unmapped: assert property (
		psel && penable && !pready && !mapped(paddr) |=> pready && pslverr)
		else $error("unmapped access did not answer with an error");

	chk_read_idle: assert property (
		!rd_en |=> prdata == 32'h00000000)
		else $error("read data showed outside its answer cycle");

endmodule : wakeup_timer
`default_nettype wire

// ===== hdl/wakeup_pkg.sv
// Constants and register map of the wake-up timer.
`default_nettype none
package wakeup_pkg;

	// ------------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------------
	localparam logic [31:0] ADDR_LOAD    = 32'hFFFF0340;
	localparam logic [31:0] ADDR_COUNT   = 32'hFFFF0344;
	localparam logic [31:0] ADDR_CTRL    = 32'hFFFF0348;
	localparam logic [31:0] ADDR_IRQCLR  = 32'hFFFF034C;
	localparam logic [31:0] ADDR_STATUS  = 32'hFFFF0350;
	localparam logic [31:0] ADDR_ENABLE  = 32'hFFFF0354;
	localparam logic [31:0] ADDR_STATCLR = 32'hFFFF0358;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [31:0] RST_LOAD  = 32'h00000000;
	localparam logic [31:0] RST_COUNT = 32'h0FFFFFFF;
	localparam logic [10:0] RST_CTRL  = 11'h000;

	// ------------------------------------------------------------------
	// Control field positions
	// ------------------------------------------------------------------
	localparam int CTRL_SRC_HI  = 10;
	localparam int CTRL_SRC_LO  = 9;
	localparam int CTRL_UP      = 8;
	localparam int CTRL_EN      = 7;
	localparam int CTRL_PERIOD  = 6;
	localparam int CTRL_FMT_HI  = 5;
	localparam int CTRL_FMT_LO  = 4;
	localparam int CTRL_PRE_HI  = 3;
	localparam int CTRL_PRE_LO  = 0;
	localparam int CTRL_W       = 11;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	localparam logic [1:0] SRC_OSC   = 2'h2;
	localparam logic [1:0] SRC_CORE  = 2'h3;
	localparam logic [1:0] FMT_HMS23 = 2'h2;
	localparam logic [1:0] FMT_HMS255 = 2'h3;
	localparam logic [3:0] PRE_DIV16    = 4'h4;
	localparam logic [3:0] PRE_DIV256   = 4'h8;
	localparam logic [3:0] PRE_DIV32768 = 4'hF;
	localparam logic [7:0] HUND_MAX  = 8'h63;
	localparam logic [7:0] SEC_MAX   = 8'h3B;
	localparam logic [7:0] HR23_MAX  = 8'h17;
	localparam logic [7:0] HR255_MAX = 8'hFF;

	// ------------------------------------------------------------------
	// Interrupt status bits
	// ------------------------------------------------------------------
	localparam int IRQ_W       = 1;
	localparam int IRQ_EXPIRE  = 0;

endpackage : wakeup_pkg
`default_nettype wire

// ===== hdl/tick_if.sv
// Interface between the timer core and its prescaler.
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
	logic       src_tick;
	logic [3:0] presc;
	logic       restart;
	logic       tick;
	modport pre (input src_tick, input presc, input restart, output tick);
	modport core (output src_tick, output presc, output restart, input tick);
endinterface : tick_if
`default_nettype wire

// ===== hdl/wakeup_prescaler.sv
// Source clock prescaler of the wake-up timer.
`timescale 1ns/1ns
`default_nettype none
module wakeup_prescaler
	import wakeup_pkg::*;
#(
	parameter int DIV_W = 15
) (
	input  wire logic pclk,
	input  wire logic presetn,
	tick_if.pre       tk
);
	if (DIV_W < 15) begin : g_div_check
		$error("wakeup_prescaler needs DIV_W of at least 15");
	end

	logic [DIV_W-1:0] cnt_r;

	// Decodes the prescale code to its last count value; unlisted codes divide by one.
	function automatic logic [DIV_W-1:0] div_last(input logic [3:0] code);
		case (code)
			PRE_DIV16:    div_last = DIV_W'(15);
			PRE_DIV256:   div_last = DIV_W'(255);
			PRE_DIV32768: div_last = DIV_W'(32767);
			default:      div_last = '0;
		endcase
	endfunction : div_last

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r   <= '0;
			tk.tick <= 1'b0;
		end else if (tk.restart) begin
			cnt_r   <= '0;
			tk.tick <= 1'b0;
		end else if (tk.src_tick) begin
			if (cnt_r >= div_last(tk.presc)) begin
				cnt_r   <= '0;
				tk.tick <= 1'b1;
			end else begin
				cnt_r   <= cnt_r + DIV_W'(1);
				tk.tick <= 1'b0;
			end
		end else begin
			tk.tick <= 1'b0;
		end
	end

	chk_div_wrap: assert property (@(posedge pclk) disable iff (!presetn)
		!tk.restart && tk.src_tick && cnt_r >= div_last(tk.presc) |=> cnt_r == '0 && tk.tick)
		else $error("prescaler did not wrap and tick at its divide limit");

endmodule : wakeup_prescaler
`default_nettype wire

// ===== tb/wakeup_timer_tb.sv
// Self-checking testbench of the wake-up timer.
`timescale 1ns/1ns
`default_nettype none
module wakeup_timer_tb
	import wakeup_pkg::*;
;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        xtal_tick;
	logic        osc_tick;
	logic        core_clk_stop;
	logic        irq;
	logic        adc_trigger;
	int          err_count;
	int          total_checks;
	int          adc_cnt;

	wakeup_timer i_wakeup_timer (
		.pclk          (pclk),
		.presetn       (presetn),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.xtal_tick     (xtal_tick),
		.osc_tick      (osc_tick),
		.core_clk_stop (core_clk_stop),
		.irq           (irq),
		.adc_trigger   (adc_trigger)
	);

	always #2 pclk = ~pclk;

	always @(posedge pclk) begin
		if (adc_trigger === 1'b1) adc_cnt <= adc_cnt + 1;
	end

	// ------------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------------
	task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : check32

	task automatic check1(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: got %b expected %b", $time, what, got, exp);
		end
	endtask : check1

	// Holds the request until pready is sampled high, then idles one cycle.
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		check32(32'(n), 32'h00000002, "access phase length");
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string what);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h00000000, r, e);
		check32(r, exp, what);
	endtask : rd_chk

	task automatic settle();
		repeat (2) @(posedge pclk);
	endtask : settle

	task automatic ticks(input bit osc, input int n);
		repeat (n) begin
			if (osc) osc_tick <= 1'b1;
			else xtal_tick <= 1'b1;
			@(posedge pclk);
			osc_tick <= 1'b0;
			xtal_tick <= 1'b0;
			@(posedge pclk);
		end
		repeat (3) @(posedge pclk);
	endtask : ticks

	task automatic setup(input logic [31:0] ctrl, input logic [31:0] load);
		wr(ADDR_CTRL, 32'h00000000);
		wr(ADDR_LOAD, load);
		wr(ADDR_CTRL, ctrl);
	endtask : setup

	task automatic run_case(input logic [31:0] ctrl, input logic [31:0] load, input bit osc,
			input int n, input logic [31:0] exp);
		setup(ctrl, load);
		ticks(osc, n);
		rd_chk(ADDR_COUNT, exp, "count after ticks");
	endtask : run_case

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic test_reset();
		logic [31:0] r;
		logic        e;
		rd_chk(ADDR_LOAD, RST_LOAD, "load reset");
		rd_chk(ADDR_COUNT, RST_COUNT, "count reset");
		rd_chk(ADDR_CTRL, 32'h00000000, "control reset");
		rd_chk(ADDR_STATUS, 32'h00000000, "status reset");
		rd_chk(ADDR_ENABLE, 32'h00000000, "enable reset");
		apb(1'b0, 32'hFFFF0360, 32'h00000000, r, e);
		check1(e, 1'b1, "unmapped error");
		check32(r, 32'h00000000, "unmapped data");
		check1(irq, 1'b0, "irq after reset");
	endtask : test_reset

	task automatic test_modes();
		run_case(32'h00000080, 32'h00000001, 1'b0, 2, 32'hFFFFFFFF);
		run_case(32'h00000280, 32'h00000003, 1'b0, 1, 32'h00000002);
		run_case(32'h00000480, 32'h00000003, 1'b0, 2, 32'h00000003);
		run_case(32'h00000480, 32'h00000003, 1'b1, 2, 32'h00000001);
		run_case(32'h00000180, 32'hFFFFFFFE, 1'b0, 2, 32'h00000000);
		run_case(32'h000001C0, 32'hFFFFFFFE, 1'b0, 2, 32'hFFFFFFFE);
		run_case(32'h000000C0, 32'h00000002, 1'b0, 3, 32'h00000002);
		run_case(32'h00000090, 32'h00000002, 1'b0, 1, 32'h00000001);
		run_case(32'h000000A8, 32'h00000000, 1'b0, 256, 32'h173B3B63);
		run_case(32'h000000B8, 32'h00000000, 1'b0, 256, 32'hFF3B3B63);
		run_case(32'h000001A8, 32'h173B3B63, 1'b0, 256, 32'h00000000);
		run_case(32'h000001B8, 32'hFF3B3B63, 1'b0, 256, 32'h00000000);
		run_case(32'h000000A8, 32'h01000000, 1'b0, 256, 32'h003B3B63);
	endtask : test_modes

	task automatic test_prescale();
		logic [3:0] pc[4] = '{4'h0, PRE_DIV16, PRE_DIV256, PRE_DIV32768};
		int         nd[4] = '{1, 16, 256, 32768};
		for (int i = 0; i < 4; i++) begin
			setup({24'h000000, 4'h8, pc[i]}, 32'h00000005);
			ticks(1'b0, nd[i] - 1);
			rd_chk(ADDR_COUNT, 32'h00000005, "count before Nth tick");
			ticks(1'b0, 1);
			rd_chk(ADDR_COUNT, 32'h00000004, "count after Nth tick");
		end
	endtask : test_prescale

	task automatic test_enable_src();
		logic [31:0] r;
		logic        e;
		setup(32'h00000080, 32'h00000009);
		ticks(1'b0, 1);
		wr(ADDR_CTRL, 32'h00000000);
		ticks(1'b0, 3);
		rd_chk(ADDR_COUNT, 32'h00000008, "count held when disabled");
		core_clk_stop <= 1'b1;
		setup(32'h00000680, 32'h00000064);
		repeat (10) @(posedge pclk);
		rd_chk(ADDR_COUNT, 32'h00000064, "core source stopped");
		core_clk_stop <= 1'b0;
		repeat (10) @(posedge pclk);
		apb(1'b0, ADDR_COUNT, 32'h00000000, r, e);
		check32(r, 32'h0000005A, "core source counts");
		core_clk_stop <= 1'b1;
		run_case(32'h00000080, 32'h00000009, 1'b0, 2, 32'h00000007);
		core_clk_stop <= 1'b0;
	endtask : test_enable_src

	task automatic test_irq();
		int a;
		wr(ADDR_IRQCLR, 32'h00000000);
		rd_chk(ADDR_STATUS, 32'h00000000, "status clear before expiry");
		wr(ADDR_ENABLE, 32'h00000000);
		a = adc_cnt;
		run_case(32'h00000080, 32'h00000001, 1'b0, 2, 32'hFFFFFFFF);
		check32(32'(adc_cnt - a), 32'h00000001, "one trigger pulse");
		rd_chk(ADDR_STATUS, 32'h00000001, "status set");
		check1(irq, 1'b0, "irq masked");
		wr(ADDR_ENABLE, 32'h00000001);
		settle();
		check1(irq, 1'b1, "irq enabled");
		wr(ADDR_COUNT, 32'h00001234);
		rd_chk(ADDR_COUNT, 32'hFFFFFFFF, "count write ignored");
		wr(ADDR_IRQCLR, 32'h0000005A);
		settle();
		check1(irq, 1'b0, "irq cleared");
		rd_chk(ADDR_STATUS, 32'h00000000, "status cleared");
		rd_chk(ADDR_IRQCLR, 32'h00000000, "clear reads zero");
		run_case(32'h00000080, 32'h00000000, 1'b0, 1, 32'hFFFFFFFF);
		check1(irq, 1'b1, "irq again");
		wr(ADDR_STATCLR, 32'h00000001);
		settle();
		check1(irq, 1'b0, "irq cleared by status clear");
	endtask : test_irq

	task automatic print_verdict();
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h00000000;
		pwdata = 32'h00000000;
		xtal_tick = 1'b0;
		osc_tick = 1'b0;
		core_clk_stop = 1'b0;
		err_count = 0;
		total_checks = 0;
		adc_cnt = 0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_reset();
		test_modes();
		test_prescale();
		test_enable_src();
		test_irq();
		print_verdict();
	end

	initial begin
		#380000;
		err_count++;
		print_verdict();
	end

endmodule : wakeup_timer_tb
`default_nettype wire
